// ---- verilog/clock_divider_reset_sync_defines.svh ----
`ifndef CLOCK_DIVIDER_RESET_SYNC_DEFINES_SVH
`define CLOCK_DIVIDER_RESET_SYNC_DEFINES_SVH

// System clock rate of the sampling clock
`define SAMPLE_CLK_MHZ 50
`define SAMPLE_CLK_PERIOD_NS 20

// Minimum reset input length, in system clock output cycles (far side duty)
`define RESET_MIN_SYS_CYCLES 4

// Reset output pipeline depth, in system clock output periods
`define RESET_RELEASE_PERIODS 2

// Flops ahead of the reset output flop; together they span the release periods
`define RESET_PIPE_STAGES 1

// First fetch delay: 6 1/2 processor clocks, counted in half periods
`define FETCH_DELAY_HALF_CYCLES 13
`define FETCH_CNT_WIDTH 4
`define FETCH_CNT_RESET 4'h0

// First instruction address after reset
`define FETCH_ADDR_WIDTH 20
`define FETCH_ADDR_VALUE 20'hFFFF0

// Reset values of pin levels
`define OSC_LEVEL_RESET 1'b0
`define RESET_PIN_LEVEL_RESET 1'b0
`define SYS_CLK_RESET 1'b1
`define RESET_OUT_RESET 1'b1

`endif

// ---- verilog/clock_divider_reset_sync_pkg.sv ----
package clock_divider_reset_sync_pkg;

	typedef enum logic [1:0] {
		CLR_IDLE = 2'h0,
		CLR_WAIT = 2'h1,
		CLR_ACTIVE = 2'h2
	} clear_state_t;

endpackage : clock_divider_reset_sync_pkg

// ---- verilog/pin_filter_sync.sv ----
`timescale 1ns/100ps

// Three-stage synchroniser; the level moves only when stages two and three agree
module pin_filter_sync #(
	parameter logic RESET_LEVEL = 1'b0
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic i_pin,
	output logic o_level
);

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic level_reg;
	logic level_next;

	always_comb begin
		level_next = level_reg;
		if (s2_reg == s3_reg) begin
			level_next = s3_reg;
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			s1_reg <= RESET_LEVEL;
			s2_reg <= RESET_LEVEL;
			s3_reg <= RESET_LEVEL;
			level_reg <= RESET_LEVEL;
		end else begin
			s1_reg <= i_pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_reg <= level_next;
		end
	end

	assign o_level = level_reg;

endmodule : pin_filter_sync

// ---- verilog/clock_divider_reset_sync.sv ----
// Operation
// - Divide oscillator input by two into a 50 percent duty system clock.
// - Edge based division, so any input duty cycle works within minimum times.
// - Outside the clear pulse, system clock toggles only on falling oscillator edges.
// - System clock keeps running during reset and bus hold.
// - Reset outputs derive from external reset, synchronised to the system clock.
// - Reset assertion clears the divider with a one oscillator clock pulse.
// - Clear pulse spans from first rising oscillator edge to the next one.
// - Clock high during clear, low at next falling edge, then toggles.
// - Reset output changes on system clock falls, lasting whole clocks.
// - Reset output deasserts two system clock periods after input release.
// - First fetch at address FFFF0 starts 6 1/2 clocks after release.
`timescale 1ns/100ps
`include "clock_divider_reset_sync_defines.svh"

module clock_divider_reset_sync
	import clock_divider_reset_sync_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic i_osc_in,
	input wire logic i_ext_reset_in_n,
	output logic o_osc_out,
	output logic o_sys_clk_out,
	output logic o_reset_out,
	output logic o_internal_reset,
	output logic o_fetch_start,
	output logic [`FETCH_ADDR_WIDTH-1:0] o_fetch_addr
);

	logic osc_lvl;
	logic res_n_lvl;
	logic osc_prev_reg;
	logic res_n_prev_reg;
	logic osc_rise;
	logic osc_fall;
	logic res_fall;
	logic res_rise;

	// Both pins come from outside this clock domain
	pin_filter_sync #(
		.RESET_LEVEL(`OSC_LEVEL_RESET)
	) u_osc_sync (
		.i_clock(i_clock),
		.i_resetn(i_resetn),
		.i_pin(i_osc_in),
		.o_level(osc_lvl)
	);

	pin_filter_sync #(
		.RESET_LEVEL(`RESET_PIN_LEVEL_RESET)
	) u_res_sync (
		.i_clock(i_clock),
		.i_resetn(i_resetn),
		.i_pin(i_ext_reset_in_n),
		.o_level(res_n_lvl)
	);

	// Edge events on the filtered levels
	always_comb begin
		osc_rise = osc_lvl & ~osc_prev_reg;
		osc_fall = ~osc_lvl & osc_prev_reg;
		res_fall = ~res_n_lvl & res_n_prev_reg;
		res_rise = res_n_lvl & ~res_n_prev_reg;
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			osc_prev_reg <= `OSC_LEVEL_RESET;
			res_n_prev_reg <= `RESET_PIN_LEVEL_RESET;
		end else begin
			osc_prev_reg <= osc_lvl;
			res_n_prev_reg <= res_n_lvl;
		end
	end

	// Clear pulse and divide-by-two
	clear_state_t clr_state_reg;
	clear_state_t clr_state_next;
	logic sys_clk_reg;
	logic sys_clk_next;
	logic osc_out_reg;
	logic osc_out_next;

	always_comb begin
		clr_state_next = clr_state_reg;
		unique case (clr_state_reg)
			CLR_IDLE: begin
				if (res_fall) begin
					clr_state_next = CLR_WAIT;
				end
			end
			CLR_WAIT: begin
				if (osc_rise && !res_fall) begin
					clr_state_next = CLR_ACTIVE;
				end
			end
			CLR_ACTIVE: begin
				if (res_fall) begin
					clr_state_next = CLR_WAIT;
				end else if (osc_rise) begin
					clr_state_next = CLR_IDLE;
				end
			end
			default: begin
				clr_state_next = CLR_IDLE;
			end
		endcase
	end

	always_comb begin
		sys_clk_next = sys_clk_reg;
		if (clr_state_next == CLR_ACTIVE) begin
			sys_clk_next = 1'b1;
		end else if (osc_fall) begin
			// Edge driven, independent of input duty cycle and of reset or hold
			sys_clk_next = ~sys_clk_reg;
		end
		// Crystal drive is the inverted oscillator level
		osc_out_next = ~osc_lvl;
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			clr_state_reg <= CLR_IDLE;
			sys_clk_reg <= `SYS_CLK_RESET;
			osc_out_reg <= ~`OSC_LEVEL_RESET;
		end else begin
			clr_state_reg <= clr_state_next;
			sys_clk_reg <= sys_clk_next;
			osc_out_reg <= osc_out_next;
		end
	end

	// Reset output synchronised to falling system clock edges
	logic sclk_fall;
	logic sclk_edge;
	logic [`RESET_PIPE_STAGES-1:0] rst_pipe_reg;
	logic [`RESET_PIPE_STAGES-1:0] rst_pipe_next;
	logic int_rst_reg;
	logic int_rst_next;

	always_comb begin
		sclk_fall = sys_clk_reg & ~sys_clk_next;
		sclk_edge = sys_clk_reg ^ sys_clk_next;
		rst_pipe_next = rst_pipe_reg;
		int_rst_next = int_rst_reg;
		if (sclk_fall) begin
			// Two stage pipe: whole clocks, release two periods after input
			rst_pipe_next = `RESET_PIPE_STAGES'({rst_pipe_reg, ~res_n_lvl});
			int_rst_next = rst_pipe_reg[`RESET_PIPE_STAGES-1];
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_pipe_reg <= {`RESET_PIPE_STAGES{`RESET_OUT_RESET}};
			int_rst_reg <= `RESET_OUT_RESET;
		end else begin
			rst_pipe_reg <= rst_pipe_next;
			int_rst_reg <= int_rst_next;
		end
	end

	// First fetch timing after reset input release
	logic fetch_armed_reg;
	logic fetch_armed_next;
	logic [`FETCH_CNT_WIDTH-1:0] fetch_cnt_reg;
	logic [`FETCH_CNT_WIDTH-1:0] fetch_cnt_next;
	logic fetch_reg;
	logic fetch_next;

	always_comb begin
		fetch_armed_next = fetch_armed_reg;
		fetch_cnt_next = fetch_cnt_reg;
		fetch_next = 1'b0;
		if (!res_n_lvl) begin
			fetch_armed_next = 1'b0;
			fetch_cnt_next = `FETCH_CNT_RESET;
		end else if (res_rise) begin
			fetch_armed_next = 1'b1;
			fetch_cnt_next = `FETCH_CNT_RESET;
		end else if (fetch_armed_reg && sclk_edge) begin
			if (fetch_cnt_reg == `FETCH_CNT_WIDTH'(`FETCH_DELAY_HALF_CYCLES - 1)) begin
				fetch_next = 1'b1;
				fetch_armed_next = 1'b0;
				fetch_cnt_next = `FETCH_CNT_RESET;
			end else begin
				fetch_cnt_next = fetch_cnt_reg + `FETCH_CNT_WIDTH'(1);
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			fetch_armed_reg <= 1'b0;
			fetch_cnt_reg <= `FETCH_CNT_RESET;
			fetch_reg <= 1'b0;
		end else begin
			fetch_armed_reg <= fetch_armed_next;
			fetch_cnt_reg <= fetch_cnt_next;
			fetch_reg <= fetch_next;
		end
	end

	// Address is a constant flop so the output is registered from reset
	logic [`FETCH_ADDR_WIDTH-1:0] fetch_addr_reg;

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			fetch_addr_reg <= `FETCH_ADDR_VALUE;
		end else begin
			fetch_addr_reg <= `FETCH_ADDR_VALUE;
		end
	end

	assign o_osc_out = osc_out_reg;
	assign o_sys_clk_out = sys_clk_reg;
	assign o_reset_out = int_rst_reg;
	assign o_internal_reset = int_rst_reg;
	assign o_fetch_start = fetch_reg;
	assign o_fetch_addr = fetch_addr_reg;

	// Checks
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_resetn);

	a_clear_holds_high: assert property (clr_state_reg == CLR_ACTIVE |-> sys_clk_reg)
		else $error("system clock low during clear pulse");

	a_clk_falls_osc: assert property ($fell(sys_clk_reg) |-> $past(osc_fall))
		else $error("system clock fell without a falling oscillator edge");

	a_clk_toggles_run: assert property (
		clr_state_next != CLR_ACTIVE && osc_fall |=> sys_clk_reg != $past(sys_clk_reg))
		else $error("system clock missed a toggle");

	a_clk_in_reset: assert property (
		int_rst_reg && osc_fall && clr_state_next == CLR_IDLE |=> $changed(sys_clk_reg))
		else $error("system clock stopped during reset");

	a_clear_starts_rise: assert property (
		$rose(clr_state_reg == CLR_ACTIVE) |-> $past(osc_rise))
		else $error("clear pulse did not start on a rising oscillator edge");

	a_clear_one_osc: assert property (
		clr_state_reg == CLR_ACTIVE && osc_rise && !res_fall |=> clr_state_reg == CLR_IDLE)
		else $error("clear pulse outlived one oscillator clock");

	a_res_starts_clear: assert property (res_fall |=> clr_state_reg == CLR_WAIT)
		else $error("reset assertion did not arm the clear pulse");

	a_reset_on_fall: assert property ($changed(int_rst_reg) |-> $past(sclk_fall))
		else $error("reset output changed off a system clock fall");

	a_reset_source: assert property (
		$changed(int_rst_reg) |-> int_rst_reg == $past(rst_pipe_reg[0]))
		else $error("reset output not fed by synchronised input");

	a_fetch_after: assert property (fetch_reg |-> $past(fetch_armed_reg && res_n_lvl))
		else $error("fetch started without a reset release");

	a_fetch_single: assert property (fetch_reg |=> !fetch_reg)
		else $error("fetch start longer than one cycle");

	a_pipe_on_fall: assert property (
		$changed(rst_pipe_reg) |-> $past(sclk_fall))
		else $error("reset pipe moved off a system clock fall");

	a_fetch_cancel: assert property (
		!res_n_lvl |=> !fetch_reg && !fetch_armed_reg)
		else $error("fetch count kept running in reset");

	a_clk_holds_still: assert property (
		!osc_fall && clr_state_next != CLR_ACTIVE |=> $stable(sys_clk_reg))
		else $error("system clock moved without a falling oscillator edge");

	a_reset_released: assert property ($fell(int_rst_reg) |-> !sys_clk_reg)
		else $error("reset output released off a system clock fall");

	a_fetch_armed_rise: assert property (res_rise |=> fetch_armed_reg)
		else $error("reset release did not arm the fetch count");

	a_pipe_takes_pin: assert property (
		sclk_fall |=> rst_pipe_reg[0] == !$past(res_n_lvl))
		else $error("reset pipe did not take the synchronised pin");

	a_clear_waits_rise: assert property (
		clr_state_reg == CLR_WAIT && !osc_rise |=> clr_state_reg == CLR_WAIT)
		else $error("clear pulse started without a rising oscillator edge");

	a_fetch_needs_edge: assert property (fetch_reg |-> $changed(sys_clk_reg))
		else $error("fetch start off a system clock edge");

	a_clear_from_wait: assert property (
		$rose(clr_state_reg == CLR_ACTIVE) |-> $past(clr_state_reg) == CLR_WAIT)
		else $error("clear pulse began without a reset assertion");

	// Main scenarios
	c_clear_pulse: cover property (clr_state_reg == CLR_WAIT ##[1:20] clr_state_reg == CLR_ACTIVE);
	c_reset_release: cover property ($fell(int_rst_reg));
	c_fetch_start: cover property ($rose(fetch_reg));
	c_clock_toggle: cover property (osc_fall ##1 $changed(sys_clk_reg));
	c_reset_assert: cover property ($rose(int_rst_reg));

endmodule : clock_divider_reset_sync

// ---- dv/osc_reset_source.sv ----
`timescale 1ns/100ps

module osc_reset_source (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic [4:0] i_high_len,
	input wire logic [4:0] i_low_len,
	input wire logic i_reset_req,
	output logic o_osc_in,
	output logic o_ext_reset_in_n
);
	logic [4:0] phase_reg;
	// Any high/low split of the oscillator
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			phase_reg <= 5'h00;
			o_osc_in <= 1'b0;
		end else if (phase_reg + 5'h01 >= (o_osc_in ? i_high_len : i_low_len)) begin
			phase_reg <= 5'h00;
			o_osc_in <= ~o_osc_in;
		end else begin
			phase_reg <= phase_reg + 5'h01;
		end
	end
	// Low from power-up; bench holds each low longer than four system clocks
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_ext_reset_in_n <= 1'b0;
		end else begin
			o_ext_reset_in_n <= ~i_reset_req;
		end
	end
endmodule : osc_reset_source

// ---- dv/clock_divider_reset_sync_test.sv ----
`timescale 1ns/100ps

module clock_divider_reset_sync_test;
	logic i_clock = 1'b0;
	logic i_resetn = 1'b0;
	logic [4:0] hi = 5'h04;
	logic [4:0] lo = 5'h04;
	logic req = 1'b1;
	logic osc_in, ext_n, osc_out, sys, rst_out, int_rst, fetch;
	logic prev_sys;
	logic [19:0] addr;
	int err_total = 0;
	int cmp_count = 0;

	always #10 i_clock = ~i_clock;

	osc_reset_source src_u (.i_clock(i_clock), .i_resetn(i_resetn), .i_high_len(hi),
		.i_low_len(lo), .i_reset_req(req), .o_osc_in(osc_in), .o_ext_reset_in_n(ext_n));

	clock_divider_reset_sync dut_u (.i_clock(i_clock), .i_resetn(i_resetn),
		.i_osc_in(osc_in), .i_ext_reset_in_n(ext_n), .o_osc_out(osc_out),
		.o_sys_clk_out(sys), .o_reset_out(rst_out), .o_internal_reset(int_rst),
		.o_fetch_start(fetch), .o_fetch_addr(addr));

	task wrap_up;
		$display("checks %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %0h seen %0h", name, exp, got);
		end
	endtask : chk

	// Cycles until the system clock changes level
	task half(output int n);
		logic cur;
		cur = sys;
		n = 0;
		while (sys === cur && n < 300) begin
			@(posedge i_clock);
			#1;
			n++;
		end
		if (n >= 300) begin
			chk("sys clock edge", 1, 0);
			wrap_up();
		end
	endtask : half

	task t_divide(input logic [4:0] h, input logic [4:0] l, input int exp);
		int a, b;
		@(posedge i_clock);
		hi <= h;
		lo <= l;
		repeat (4) half(a);
		if (sys !== 1'b1) half(a);
		half(a);
		half(b);
		chk("high time", exp, a);
		chk("low time", exp, b);
		chk("osc drive", 1, osc_out);
		chk("reset out level", {31'h0, req}, rst_out);
	endtask : t_divide

	task t_release;
		int n, edges, falls, at;
		half(n);
		@(posedge i_clock);
		req <= 1'b0;
		edges = 0;
		falls = 0;
		at = 0;
		n = 0;
		prev_sys = sys;
		while (fetch !== 1'b1 && n < 600) begin
			@(posedge i_clock);
			#1;
			n++;
			if (sys !== prev_sys) begin
				edges++;
				if (sys === 1'b0) falls++;
			end
			if (at == 0 && rst_out === 1'b0) begin
				at = falls;
				chk("reset out on fall", 0, sys);
			end
			prev_sys = sys;
		end
		chk("fetch seen", 1, fetch);
		if (fetch !== 1'b1) wrap_up();
		chk("edges to fetch", 13, edges);
		chk("fetch address", 20'hFFFF0, addr);
		chk("falls to release", 2, at);
		chk("internal reset", 0, int_rst);
		@(posedge i_clock);
		#1;
		chk("fetch pulse end", 0, fetch);
	endtask : t_release

	task t_clear;
		int a, b;
		while (sys !== 1'b1) half(a);
		repeat (4) @(posedge i_clock);
		req <= 1'b1;
		half(a);
		half(a);
		half(b);
		chk("clear forces early high", 1, a < 12);
		chk("high through clear", 1, b >= 20 && b <= 28);
		half(a);
		chk("toggle after clear", 16, a);
		chk("reset held", 1, rst_out);
	endtask : t_clear

	initial begin
		repeat (8) @(posedge i_clock);
		i_resetn <= 1'b1;
		t_divide(5'h04, 5'h04, 8);
		t_divide(5'h08, 5'h08, 16);
		t_release();
		t_divide(5'h03, 5'h0D, 16);
		t_divide(5'h08, 5'h08, 16);
		t_clear();
		repeat (100) @(posedge i_clock);
		t_release();
		wrap_up();
	end
endmodule : clock_divider_reset_sync_test
